// ==== common/smc_pkg.sv ====
// constants and types shared by the mode, control-bus and sensor clock logic
package smc_pkg;

   // ****************************************************************
   // register offsets on the control bus
   // ****************************************************************
   localparam logic [7:0] MODE_REG_OFF    = 8'h03;
   localparam logic [7:0] RATIO_A_OFF     = 8'h06;
   localparam logic [7:0] RATIO_B_OFF     = 8'h07;
   localparam logic [7:0] STATUS_OFF      = 8'h08;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int         MODE_OVR_BIT    = 4;
   localparam int         RATIO_M_LSB     = 3;
   localparam int         RATIO_M_W       = 5;
   localparam int         RATIO_HS_W      = 3;
   localparam int         RATIO_N_W       = 8;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] RATIO_A_RST     = 8'h0a;
   localparam logic [7:0] RATIO_B_RST     = 8'h1b;

   // ****************************************************************
   // control-bus target addresses (7 bit)
   // ****************************************************************
   localparam logic [6:0] BUS_ADDR_LO     = 7'h18;
   localparam logic [6:0] BUS_ADDR_HI     = 7'h19;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      SMC_MODE_SYNC = 3'h0,
      SMC_MODE_EXT  = 3'h2,
      SMC_MODE_INT  = 3'h3,
      SMC_MODE_PAR  = 3'h5
   } smc_mode_t;

   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_ADDR  = 7'h02,
      ST_AACK  = 7'h04,
      ST_REG   = 7'h08,
      ST_DACK  = 7'h10,
      ST_WDATA = 7'h20,
      ST_RDATA = 7'h40
   } smc_bus_st_t;

endpackage

// ==== hdl/smc_clk_gen.sv ====
// fractional sensor reference clock generator
`timescale 1ns/10ps
module smc_clk_gen
   import smc_pkg::*;
#(
   parameter int M_W  = RATIO_M_W,
   parameter int N_W  = RATIO_N_W,
   parameter int HS_W = RATIO_HS_W
)(
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            enable,
   input  wire logic            fc_tick,
   input  wire logic [HS_W-1:0] hs_code,
   input  wire logic [M_W-1:0]  ratio_m,
   input  wire logic [N_W-1:0]  ratio_n,
   output logic                 clk_o
);
   localparam int PRE_W = 1 << HS_W;

   if (M_W >= N_W || HS_W > 4 || HS_W < 1) begin : g_chk
      $error("smc_clk_gen: unsupported widths");
   end

   logic [PRE_W-1:0] pre_cnt;
   logic [N_W:0]     acc;

   wire  [PRE_W-1:0] hs_div_m1 = (PRE_W'(1) << hs_code) - PRE_W'(1);
   // >= so a divider shortened mid-count steps now instead of wrapping the count
   wire              step      = fc_tick && (pre_cnt >= hs_div_m1);
   wire  [N_W+1:0]   sum       = (N_W+2)'(acc) + (N_W+2)'({ratio_m, 1'b0});
   wire  [N_W+1:0]   sum_n     = sum - (N_W+2)'(ratio_n);
   wire              wrap      = (sum >= (N_W+2)'(ratio_n)) && (ratio_n != '0);
   // an accumulator that could outrun n is cleared; 2m below n is the host's duty
   wire              over      = sum_n >= (N_W+2)'(ratio_n);
   wire  [N_W:0]     next_acc  = !wrap ? (N_W+1)'(sum) : over ? '0 : (N_W+1)'(sum_n);

   // fc times m over divider times n
   always_ff @(posedge clk) begin
      if (rst || !enable) begin
         pre_cnt <= '0;
         acc     <= '0;
         clk_o   <= 1'b0;
      end else if (fc_tick) begin
         pre_cnt <= step ? '0 : pre_cnt + PRE_W'(1);
         if (step && ratio_n != '0) begin
            acc <= next_acc;
            if (wrap) begin
               clk_o <= ~clk_o;
            end
         end
      end
   end

endmodule

// ==== hdl/smc_top.sv ====
// strap-driven mode selection, control-bus target and sensor clock output
`timescale 1ns/10ps
module smc_top
   import smc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       power_down_input,
   input  wire logic [2:0] mode_strap_code,
   input  wire logic [2:0] address_strap_input,
   input  wire logic       fc_tick,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   output logic            clk_out,
   output logic            clk_out_oe,
   output logic            ref_sel_back_channel,
   output logic            ref_sel_external,
   output logic            ref_sel_always_on,
   output logic            i2c_io_3v3
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic       pdb_s1, pdb_s2, pdb_d;
   logic       scl_s1, scl_s2, scl_d;
   logic       sda_s1, sda_s2, sda_d;
   logic [2:0] mstrap_s1, mstrap_s2;
   logic [2:0] astrap_s1, astrap_s2;

   always_ff @(posedge mclk) begin
      if (rst) begin
         pdb_s1    <= 1'b0;
         pdb_s2    <= 1'b0;
         pdb_d     <= 1'b0;
         scl_s1    <= 1'b1;
         scl_s2    <= 1'b1;
         scl_d     <= 1'b1;
         sda_s1    <= 1'b1;
         sda_s2    <= 1'b1;
         sda_d     <= 1'b1;
         mstrap_s1 <= 3'h0;
         mstrap_s2 <= 3'h0;
         astrap_s1 <= 3'h0;
         astrap_s2 <= 3'h0;
      end else begin
         pdb_s1    <= power_down_input;
         pdb_s2    <= pdb_s1;
         pdb_d     <= pdb_s2;
         scl_s1    <= scl_in;
         scl_s2    <= scl_s1;
         scl_d     <= scl_s2;
         sda_s1    <= sda_in;
         sda_s2    <= sda_s1;
         sda_d     <= sda_s2;
         mstrap_s1 <= mode_strap_code;
         mstrap_s2 <= mstrap_s1;
         astrap_s1 <= address_strap_input;
         astrap_s2 <= astrap_s1;
      end
   end

   // ****************************************************************
   // decode
   // ****************************************************************
   logic        configured;
   logic [2:0]  mode;
   logic        mode_ovr;
   logic        addr_hi;
   logic [7:0]  ratio_a;
   logic [7:0]  ratio_b;
   smc_bus_st_t st, next_st;
   logic [3:0]  bit_cnt, next_cnt;
   logic [7:0]  shreg, next_sh;
   logic [7:0]  ptr, next_ptr;
   logic        rw, next_rw;
   logic        next_oe;

   wire pdb_rise  = pdb_s2 & ~pdb_d;
   wire scl_rise  = scl_s2 & ~scl_d;
   wire scl_fall  = ~scl_s2 & scl_d;
   wire bus_start = scl_s2 & scl_d & ~sda_s2 & sda_d;
   wire bus_stop  = scl_s2 & scl_d & sda_s2 & ~sda_d;

   // only the four mode codes are taken
   wire strap_ok  = mstrap_s2 == SMC_MODE_SYNC || mstrap_s2 == SMC_MODE_EXT
                 || mstrap_s2 == SMC_MODE_INT  || mstrap_s2 == SMC_MODE_PAR;
   wire wmode_ok  = shreg[2:0] == SMC_MODE_SYNC || shreg[2:0] == SMC_MODE_EXT
                 || shreg[2:0] == SMC_MODE_INT  || shreg[2:0] == SMC_MODE_PAR;

   // codes 2 and 4 pick the high address
   wire strap_hi  = astrap_s2 == 3'h2 || astrap_s2 == 3'h4;
   wire strap_3v3 = astrap_s2 == 3'h3 || astrap_s2 == 3'h4;
   wire [6:0] dev_addr = addr_hi ? BUS_ADDR_HI : BUS_ADDR_LO;

   // no sensor clock from the always-on oscillator mode
   wire clk_en    = configured && mode != SMC_MODE_INT;

   wire wr_en     = st == ST_WDATA && scl_fall && bit_cnt == 4'h8
                 && !bus_start && !bus_stop;
   wire [7:0] rd_ptr  = (st == ST_RDATA) ? ptr + 8'h01 : ptr;
   wire [7:0] rd_data = (rd_ptr == MODE_REG_OFF) ? {3'h0, mode_ovr, 1'b0, mode}
                      : (rd_ptr == RATIO_A_OFF)  ? ratio_a
                      : (rd_ptr == RATIO_B_OFF)  ? ratio_b
                      : (rd_ptr == STATUS_OFF)   ? {5'h00, i2c_io_3v3, clk_out_oe, configured}
                      : 8'h00;

   // ****************************************************************
   // power-up straps and configuration registers
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         configured <= 1'b0;
         mode       <= SMC_MODE_SYNC;
         mode_ovr   <= 1'b0;
         addr_hi    <= 1'b0;
         i2c_io_3v3 <= 1'b0;
         ratio_a    <= RATIO_A_RST;
         ratio_b    <= RATIO_B_RST;
      end else if (!pdb_s2) begin
         configured <= 1'b0;
      end else if (pdb_rise) begin
         // latch mode strap on rising edge
         mode       <= strap_ok ? mstrap_s2 : SMC_MODE_SYNC;
         mode_ovr   <= 1'b0;
         addr_hi    <= strap_hi;
         i2c_io_3v3 <= strap_3v3;
         configured <= 1'b1;
      end else if (wr_en) begin
         // mode read and changed over the bus
         if (ptr == MODE_REG_OFF) begin
            mode_ovr <= shreg[MODE_OVR_BIT];
            // override bit gates the mode field
            if (shreg[MODE_OVR_BIT] && wmode_ok) begin
               mode <= shreg[2:0];
            end
         end
         if (ptr == RATIO_A_OFF) begin
            ratio_a <= shreg;
         end
         if (ptr == RATIO_B_OFF) begin
            ratio_b <= shreg;
         end
      end
   end

   // ****************************************************************
   // control-bus target
   // ****************************************************************
   // byte-wise target with auto-increment pointer
   always_comb begin
      next_st  = st;
      next_cnt = bit_cnt;
      next_sh  = shreg;
      next_ptr = ptr;
      next_rw  = rw;
      next_oe  = sda_oe;
      if (!configured || bus_stop) begin
         next_st = ST_IDLE;
         next_oe = 1'b0;
      end else if (bus_start) begin
         next_st  = ST_ADDR;
         next_cnt = 4'h0;
         next_oe  = 1'b0;
      end else begin
         case (st)
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (scl_rise && bit_cnt != 4'h8) begin
                  next_sh  = {shreg[6:0], sda_s2};
                  next_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  next_cnt = 4'h0;
                  next_oe  = 1'b1;
                  next_st  = ST_DACK;
                  if (st == ST_ADDR) begin
                     next_rw = shreg[0];
                     next_st = ST_AACK;
                     // answer only on the strapped address
                     if (shreg[7:1] != dev_addr) begin
                        next_oe = 1'b0;
                        next_st = ST_IDLE;
                     end
                  end else if (st == ST_REG) begin
                     next_ptr = shreg;
                  end else begin
                     next_ptr = ptr + 8'h01;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  next_oe = 1'b0;
                  next_st = ST_REG;
                  if (rw) begin
                     next_sh  = rd_data;
                     next_oe  = ~rd_data[7];
                     next_cnt = 4'h0;
                     next_st  = ST_RDATA;
                  end
               end
            end
            ST_DACK: begin
               if (scl_fall) begin
                  next_oe = 1'b0;
                  next_st = ST_WDATA;
               end
            end
            ST_RDATA: begin
               // bit_cnt 8 marks the host acknowledge slot
               if (bit_cnt == 4'h8 && scl_rise && sda_s2) begin
                  next_st = ST_IDLE;
               end else if (scl_fall) begin
                  if (bit_cnt == 4'h7) begin
                     next_oe  = 1'b0;
                     next_cnt = 4'h8;
                  end else if (bit_cnt == 4'h8) begin
                     next_ptr = ptr + 8'h01;
                     next_sh  = rd_data;
                     next_oe  = ~rd_data[7];
                     next_cnt = 4'h0;
                  end else begin
                     next_sh  = {shreg[6:0], 1'b0};
                     next_oe  = ~shreg[6];
                     next_cnt = bit_cnt + 4'h1;
                  end
               end
            end
            default: begin
               next_st = ST_IDLE;
               next_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st      <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg   <= 8'h00;
         ptr     <= 8'h00;
         rw      <= 1'b0;
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         st      <= next_st;
         bit_cnt <= next_cnt;
         shreg   <= next_sh;
         ptr     <= next_ptr;
         rw      <= next_rw;
         sda_oe  <= next_oe;
         sda_out <= 1'b0;
      end
   end

   // ****************************************************************
   // reference selection and clock pin
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_sel_back_channel <= 1'b0;
         ref_sel_external     <= 1'b0;
         ref_sel_always_on    <= 1'b0;
         clk_out_oe           <= 1'b0;
      end else begin
         // synchronous mode uses the back channel
         ref_sel_back_channel <= configured && mode == SMC_MODE_SYNC;
         // external and parallel modes use the input
         ref_sel_external     <= configured && (mode == SMC_MODE_EXT || mode == SMC_MODE_PAR);
         ref_sel_always_on    <= configured && mode == SMC_MODE_INT;
         // strap pin turns into clock driver
         clk_out_oe           <= clk_en;
      end
   end

   smc_clk_gen #(
      .M_W  (RATIO_M_W),
      .N_W  (RATIO_N_W),
      .HS_W (RATIO_HS_W)
   ) u_clk_gen (
      .clk     (mclk),
      .rst     (rst),
      .enable  (clk_en),
      .fc_tick (fc_tick),
      .hs_code (ratio_a[RATIO_HS_W-1:0]),
      .ratio_m (ratio_a[RATIO_M_LSB +: RATIO_M_W]),
      .ratio_n (ratio_b),
      .clk_o   (clk_out)
   );

endmodule

// ==== tb/smc_monitor.sv ====
// port-level checks for the mode, control-bus and sensor clock block
`timescale 1ns/10ps
module smc_monitor (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       power_down_input,
   input wire logic [2:0] mode_strap_code,
   input wire logic [2:0] address_strap_input,
   input wire logic       fc_tick,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       clk_out,
   input wire logic       clk_out_oe,
   input wire logic       ref_sel_back_channel,
   input wire logic       ref_sel_external,
   input wire logic       ref_sel_always_on,
   input wire logic       i2c_io_3v3
);
   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic any_ref;
   assign any_ref = ref_sel_back_channel | ref_sel_external | ref_sel_always_on;
   a_clk_off_int: assert property (
      ref_sel_always_on && $past(ref_sel_always_on) |-> !clk_out) else $error("clock in int mode");
   a_ref_onehot: assert property (
      $onehot0({ref_sel_back_channel, ref_sel_external, ref_sel_always_on}))
      else $error("two reference sources");
   a_ref_needs_pwr: assert property (
      $fell(power_down_input) |-> ##[1:8] !any_ref) else $error("reference kept when down");
   a_oe_after_pwr: assert property (
      $rose(power_down_input) && mode_strap_code != 3'h3 |-> ##[2:8] clk_out_oe)
      else $error("pin not switched");
   a_io_volt: assert property (
      $rose(clk_out_oe) |-> i2c_io_3v3 == (address_strap_input inside {3'h3, 3'h4}))
      else $error("bus voltage wrong");
   a_sda_drive_low: assert property (
      sda_out == 1'b0) else $error("data pin driven high");
   a_no_ack_unconf: assert property (
      !power_down_input [*5] |-> !sda_oe) else $error("bus answer while down");
   a_ack_scl_low: assert property (
      $changed(sda_oe) |-> !scl_in) else $error("data changed in clock high");
   a_clk_needs_oe: assert property (
      $rose(clk_out) |-> $past(clk_out_oe)) else $error("clock before pin switch");
   c_ext: cover property (ref_sel_external);
   c_clk: cover property ($rose(clk_out));
   c_ack: cover property ($rose(sda_oe));
endmodule
bind smc_top smc_monitor u_smc_monitor (.mclk(mclk), .rst(rst),
   .power_down_input(power_down_input), .mode_strap_code(mode_strap_code),
   .address_strap_input(address_strap_input), .fc_tick(fc_tick), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .clk_out(clk_out),
   .clk_out_oe(clk_out_oe), .ref_sel_back_channel(ref_sel_back_channel),
   .ref_sel_external(ref_sel_external), .ref_sel_always_on(ref_sel_always_on),
   .i2c_io_3v3(i2c_io_3v3));

// ==== tb/smc_i2c_host.sv ====
// control-bus host model on an open-drain data line with pull-up
`timescale 1ns/10ps
module smc_i2c_host (
   input  wire logic mclk,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   // ****************************************
   // bus cycles, bit phases of five mclk
   // ****************************************
   logic hold_lo = 1'b0;
   initial scl = 1'b1;
   // released line floats up through the pull-up
   assign sda = !(hold_lo || sda_oe);
   task automatic hw(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic bit_x(input logic b, output logic r);
      hold_lo <= !b;
      hw(5);
      scl <= 1'b1;
      hw(5);
      r = sda;
      hw(5);
      scl <= 1'b0;
      hw(5);
   endtask
   task automatic start();
      hold_lo <= 1'b0;
      hw(5);
      scl <= 1'b1;
      hw(10);
      hold_lo <= 1'b1;
      hw(10);
      scl <= 1'b0;
      hw(5);
   endtask
   task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      // last bit always released: target acks writes, host refuses more reads
      bit_x(1'b1, r);
      ack = !r;
   endtask
   task automatic reg_acc(input logic [6:0] a, input logic rd, input logic [7:0] off,
                          input logic [7:0] wd, output logic [7:0] q, output logic ok);
      logic k0, k1, k2, k3;
      @(posedge mclk);
      start();
      byte_x({a, 1'b0}, q, k0);
      byte_x(off, q, k1);
      if (rd) begin
         start();
         byte_x({a, 1'b1}, q, k2);
         byte_x(8'hff, q, k3);
      end else begin
         byte_x(wd, q, k2);
      end
      hold_lo <= 1'b1;
      hw(5);
      scl <= 1'b1;
      hw(10);
      hold_lo <= 1'b0;
      hw(10);
      ok = k0 & k1 & k2;
   endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for mode straps, control bus and sensor clock
`timescale 1ns/10ps
module testbench
   import smc_pkg::*;
;
   // ****************************************
   // signals and checks
   // ****************************************
   logic       mclk = 1'b0, rst = 1'b1, power_down_input = 1'b0, fc_tick = 1'b0;
   logic       tick_en = 1'b0, clk_d = 1'b0;
   logic [2:0] mode_strap_code = 3'h0, address_strap_input = 3'h1;
   logic       scl_in, sda_in, sda_out, sda_oe, clk_out, clk_out_oe;
   logic       ref_bc, ref_ext, ref_aon, io3;
   int         num_errors = 0, checks = 0, rises = 0, ticks = 0;
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      clk_d <= clk_out;
      if (clk_out && !clk_d) rises <= rises + 1;
      if (fc_tick) ticks <= ticks + 1;
      fc_tick <= tick_en & 1'($urandom);
   end
   smc_top u_smc_top (.mclk(mclk), .rst(rst), .power_down_input(power_down_input),
      .mode_strap_code(mode_strap_code), .address_strap_input(address_strap_input),
      .fc_tick(fc_tick), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .clk_out(clk_out), .clk_out_oe(clk_out_oe),
      .ref_sel_back_channel(ref_bc), .ref_sel_external(ref_ext),
      .ref_sel_always_on(ref_aon), .i2c_io_3v3(io3));
   smc_i2c_host u_smc_i2c_host (.mclk(mclk), .sda_oe(sda_oe), .scl(scl_in), .sda(sda_in));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [2:0] exp_sel(input logic [2:0] m);
      return {m == 3'h0, m == 3'h2 || m == 3'h5, m == 3'h3};
   endfunction
   function automatic int exp_rises(input int t, input int m, input int c, input int n);
      return ((t >> c) * 2 * m / n) / 2;
   endfunction
   task automatic pwr_up(input logic [2:0] m, input logic [2:0] idx);
      @(posedge mclk);
      power_down_input <= 1'b0;
      repeat (10) @(posedge mclk);
      mode_strap_code <= m;
      address_strap_input <= idx;
      repeat (5) @(posedge mclk);
      power_down_input <= 1'b1;
      repeat (12) @(posedge mclk);
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      num_errors++;
      print_verdict();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      logic [7:0] q;
      logic       ok;
      logic [4:0] m;
      logic [2:0] c;
      logic [7:0] n;
      int         r0, t0, d, w;
      logic [7:0] offs[4] = '{MODE_REG_OFF, RATIO_A_OFF, RATIO_B_OFF, STATUS_OFF};
      logic [7:0] exps[4] = '{8'h05, RATIO_A_RST, RATIO_B_RST, 8'h07};
      logic [2:0] modes[4] = '{3'h0, 3'h2, 3'h3, 3'h5};
      void'($urandom(55937));
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      pwr_up(3'h5, 3'h3);
      @(negedge mclk);
      chk(16'({ref_bc, ref_ext, ref_aon, clk_out_oe, io3}), 16'h000b);
      foreach (offs[i]) begin
         u_smc_i2c_host.reg_acc(BUS_ADDR_LO, 1'b1, offs[i], 8'h00, q, ok);
         chk({7'h0, ok, q}, {8'h01, exps[i]});
      end
      u_smc_i2c_host.reg_acc(BUS_ADDR_HI, 1'b1, MODE_REG_OFF, 8'h00, q, ok);
      chk(16'(ok), 16'h0000);
      u_smc_i2c_host.reg_acc(BUS_ADDR_LO, 1'b0, MODE_REG_OFF, 8'h02, q, ok);
      u_smc_i2c_host.reg_acc(BUS_ADDR_LO, 1'b1, MODE_REG_OFF, 8'h00, q, ok);
      chk(16'(q), 16'h0005);
      tick_en <= 1'b1;
      foreach (modes[i]) begin
         u_smc_i2c_host.reg_acc(BUS_ADDR_LO, 1'b0, MODE_REG_OFF, 8'h10 | modes[i], q, ok);
         r0 = rises;
         repeat (800) @(posedge mclk);
         @(negedge mclk);
         chk(16'({ref_bc, ref_ext, ref_aon}), 16'(exp_sel(modes[i])));
         chk(16'(rises == r0), 16'(modes[i] == 3'h3));
         u_smc_i2c_host.reg_acc(BUS_ADDR_LO, 1'b1, MODE_REG_OFF, 8'h00, q, ok);
         chk(16'(q), 16'(8'h10 | modes[i]));
      end
      for (int k = 0; k < 3; k++) begin
         // divider kept small so fc over divider stays in range
         m = 5'($urandom_range(1, 12));
         c = 3'($urandom_range(0, 2));
         n = 8'(2 * m + 1 + $urandom_range(0, 60));
         if (k == 0) begin
            m = 5'h01;
            c = 3'h2;
            n = 8'h1b;
         end
         u_smc_i2c_host.reg_acc(BUS_ADDR_LO, 1'b0, RATIO_A_OFF, {m, c}, q, ok);
         u_smc_i2c_host.reg_acc(BUS_ADDR_LO, 1'b0, RATIO_B_OFF, n, q, ok);
         // open the window on a rise: divider count is zero, accumulator below 2m
         w = 0;
         while (!(clk_out && !clk_d) && w < 4000) begin
            @(posedge mclk);
            w++;
         end
         chk(16'(w < 4000), 16'h0001);
         // the rise just seen is counted at this edge
         r0 = rises + 1;
         t0 = ticks;
         repeat (4000) @(posedge mclk);
         @(negedge mclk);
         // the last tick of the window may not show as a rise yet
         d = exp_rises(ticks - t0, int'(m), int'(c), int'(n)) - (rises - r0);
         chk(16'(d >= -1 && d <= 1), 16'h0001);
      end
      m = 5'(modes[$urandom_range(0, 3)]);
      pwr_up(m[2:0], 3'h2);
      u_smc_i2c_host.reg_acc(BUS_ADDR_HI, 1'b1, MODE_REG_OFF, 8'h00, q, ok);
      @(negedge mclk);
      chk({7'h0, ok, q}, {8'h01, 5'h00, m[2:0]});
      chk(16'(io3), 16'h0000);
      print_verdict();
   end
endmodule
